/* File: core/tmc_defines.svh */
// Purpose: constants of the 8-bit timer counter and compare block
// Assumes: one system clock; the oscillator pin input is sampled by two flops
// Notes: waveform mode codes 0 normal, 1 phase correct, 2 clear on match, 3 fast
//
// Overview of operation
// - Timer ticks from io clock, or oscillator pin when async select is one.
// - Each timer tick clears, increments or decrements counter per mode.
// - Clock select field zero stops the counter.
// - Counter stays readable and writable with or without timer ticks.
// - CPU counter write beats clear or count in same cycle.
// - Two waveform mode bits choose the counting sequence.
// - Overflow flag set per mode, usable as interrupt source.
// - Equality of counter and compare sets compare flag next timer tick.
// - Compare interrupt raised while enable is one and flag set.
// - Compare flag clears on service ack or software write of one.
// - Output derives from match, mode bits, output mode bits, max, bottom.
// - Compare value double buffered in PWM modes only.
// - Buffered value loads only at top or bottom of sequence.
// - CPU compare access reaches buffer when buffered, else active register.
// - Force strobe in non-PWM acts as match on output only.
// - Counter write blocks matches in next timer tick, even stopped.
// - Output state keeps its value across waveform mode changes.
// - Output mode bits unbuffered, govern first match after write.
// - Nonzero output mode bits route waveform to pin; direction stays separate.
// - Output mode zero leaves output state unchanged at match.
// - Normal mode code 0: up count, wraps FF to 00, sets overflow.
// - Bottom means counter 00, max means counter FF.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_WGM_NORMAL 2'h0
`define TMC_WGM_PHASE 2'h1
`define TMC_WGM_CTC 2'h2
`define TMC_WGM_FAST 2'h3
`define TMC_BOTTOM 8'h00
`define TMC_MAX 8'hFF
`define TMC_CNT_RST 8'h00
`define TMC_CMP_RST 8'h00
`define TMC_COM_NONE 2'h0
`define TMC_COM_TOGGLE 2'h1
`define TMC_COM_CLEAR 2'h2
`define TMC_COM_SET 2'h3
`define TMC_CS_STOP 3'h0
`define TMC_PRE_W 10
`endif

/* File: core/tmc_pkg.sv */
// Purpose: types of the timer counter block
// Assumes: nothing
// Notes: none
`default_nettype none
package tmc_pkg;
	typedef enum logic [1:0] {
		TMC_NORMAL,
		TMC_PHASE,
		TMC_CTC,
		TMC_FAST
	} tmc_wgm_t;
endpackage : tmc_pkg
`default_nettype wire

/* File: core/tmc_sync2.sv */
// Purpose: two-flop synchroniser for a level
// Assumes: input comes from outside clk_sys
// Notes: only the second flop is visible
`default_nettype none
module tmc_sync2 (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	logic meta_ff;
	logic sync_ff;
	logic nxt_meta;
	logic nxt_sync;
	always_comb begin
		nxt_meta = d;
		nxt_sync = meta_ff;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end
	assign q = sync_ff;
endmodule : tmc_sync2
`default_nettype wire

/* File: core/tmc_tick.sv */
// Purpose: timer tick generator from clock select and source
// Assumes: osc_sync already synchronised to clk_sys
// Notes: select 1 passes each source tick, 2..7 divide by 8,32,64,128,256,1024
`default_nettype none
`include "tmc_defines.svh"
module tmc_tick #(
	parameter int PRE_W = `TMC_PRE_W
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic async_clock_select,
	input wire logic osc_sync,
	input wire logic [2:0] clock_select_field,
	output logic timer_tick
);
	logic osc_prev_ff;
	logic [PRE_W-1:0] pre_ff;
	logic tick_ff;
	logic nxt_osc_prev;
	logic [PRE_W-1:0] nxt_pre;
	logic nxt_tick;
	logic src_tick;
	logic [PRE_W-1:0] mask;
	always_comb begin
		nxt_osc_prev = osc_sync;
		// Async source ticks on oscillator rising edge, else every io clock
		src_tick = async_clock_select ? (osc_sync & ~osc_prev_ff) : 1'b1;
		case (clock_select_field)
			3'h2: mask = PRE_W'(10'h007);
			3'h3: mask = PRE_W'(10'h01F);
			3'h4: mask = PRE_W'(10'h03F);
			3'h5: mask = PRE_W'(10'h07F);
			3'h6: mask = PRE_W'(10'h0FF);
			3'h7: mask = PRE_W'(10'h3FF);
			default: mask = '0;
		endcase
		nxt_pre = pre_ff;
		nxt_tick = 1'b0;
		if (clock_select_field == `TMC_CS_STOP) begin
			nxt_pre = '0;
		end else if (src_tick) begin
			nxt_pre = (pre_ff & mask) + PRE_W'(1);
			nxt_tick = ((pre_ff & mask) == mask);
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			osc_prev_ff <= 1'b0;
			pre_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			osc_prev_ff <= nxt_osc_prev;
			pre_ff <= nxt_pre;
			tick_ff <= nxt_tick;
		end
	end
	assign timer_tick = tick_ff;
endmodule : tmc_tick
`default_nettype wire

/* File: core/tmc_timer.sv */
// Purpose: 8-bit timer counter with compare, force strobe and pin override
// Assumes: CPU strobes are one-cycle pulses on clk_sys; osc_pin_in is asynchronous
// Notes: the flags are cleared by irq ack pulses or write-one strobes
`default_nettype none
`include "tmc_defines.svh"
module tmc_timer (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic osc_pin_in,
	input wire logic async_clock_select,
	input wire logic [2:0] clock_select_field,
	input wire logic [1:0] waveform_mode_bits,
	input wire logic [1:0] output_mode_bits,
	input wire logic compare_irq_enable,
	input wire logic overflow_irq_enable,
	input wire logic counter_wr,
	input wire logic [7:0] counter_wdata,
	input wire logic compare_wr,
	input wire logic [7:0] compare_wdata,
	input wire logic force_compare_strobe,
	input wire logic compare_flag_clr,
	input wire logic overflow_flag_clr,
	input wire logic compare_irq_ack,
	input wire logic overflow_irq_ack,
	input wire logic port_data,
	input wire logic output_pin_direction,
	output logic [7:0] counter_value,
	output logic [7:0] compare_value,
	output logic compare_flag,
	output logic overflow_flag,
	output logic compare_irq,
	output logic overflow_irq,
	output logic compare_output_state,
	output logic osc_pin_out,
	output logic pin_out,
	output logic pin_oe
);
	////////////////////////////////////////////////////////////////////////////
	// Clock source
	logic osc_sync;
	logic timer_tick;
	tmc_sync2 u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.d(osc_pin_in),
		.q(osc_sync)
	);
	tmc_tick u_tick (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_clock_select(async_clock_select),
		.osc_sync(osc_sync),
		.clock_select_field(clock_select_field),
		.timer_tick(timer_tick)
	);
	////////////////////////////////////////////////////////////////////////////
	// State
	tmc_pkg::tmc_wgm_t wgm;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic down_ff;
	logic nxt_down;
	logic [7:0] cmp_ff;
	logic [7:0] nxt_cmp;
	logic [7:0] buf_ff;
	logic [7:0] nxt_buf;
	logic block_ff;
	logic nxt_block;
	logic match_ff;
	logic nxt_match;
	logic ocf_ff;
	logic nxt_ocf;
	logic tov_ff;
	logic nxt_tov;
	logic oc_ff;
	logic nxt_oc;
	logic cirq_ff;
	logic nxt_cirq;
	logic oirq_ff;
	logic nxt_oirq;
	logic pin_ff;
	logic nxt_pin;
	logic oe_ff;
	logic nxt_oe;
	logic [7:0] cmpv_ff;
	logic [7:0] nxt_cmpv;
	logic pwm;
	logic at_bottom;
	logic at_max;
	logic match;
	logic tov_set;
	logic ocf_set;
	logic ctc_clear;
	assign wgm = tmc_pkg::tmc_wgm_t'(waveform_mode_bits);
	////////////////////////////////////////////////////////////////////////////
	// Counter, compare and waveform
	always_comb begin
		pwm = (wgm == tmc_pkg::TMC_PHASE) || (wgm == tmc_pkg::TMC_FAST);
		at_bottom = (cnt_ff == `TMC_BOTTOM);
		at_max = (cnt_ff == `TMC_MAX);
		// Comparator runs continuously; blocked for one tick after a counter write
		match = (cnt_ff == cmp_ff) && !block_ff;
		nxt_cnt = cnt_ff;
		nxt_down = down_ff;
		nxt_cmp = cmp_ff;
		nxt_buf = buf_ff;
		nxt_block = block_ff;
		nxt_match = match_ff;
		nxt_oc = oc_ff;
		tov_set = 1'b0;
		ocf_set = 1'b0;
		ctc_clear = 1'b0;
		if (timer_tick) begin
			nxt_block = 1'b0;
			nxt_match = match;
			ocf_set = match_ff;
			case (wgm)
				tmc_pkg::TMC_NORMAL: begin
					nxt_cnt = cnt_ff + 8'h01;
					nxt_down = 1'b0;
					tov_set = at_max;
				end
				tmc_pkg::TMC_CTC: begin
					ctc_clear = match;
					nxt_cnt = ctc_clear ? `TMC_BOTTOM : cnt_ff + 8'h01;
					nxt_down = 1'b0;
					tov_set = at_max && !ctc_clear;
				end
				tmc_pkg::TMC_FAST: begin
					nxt_cnt = cnt_ff + 8'h01;
					nxt_down = 1'b0;
					tov_set = at_max;
					if (at_max) begin
						nxt_cmp = buf_ff;
					end
				end
				default: begin
					// Dual slope: turn at max and at bottom
					if (!down_ff && at_max) begin
						nxt_down = 1'b1;
						nxt_cmp = buf_ff;
					end else if (down_ff && at_bottom) begin
						nxt_down = 1'b0;
					end
					nxt_cnt = nxt_down ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
					tov_set = down_ff && at_bottom;
				end
			endcase
			// Output state; mode bits read live so a change acts at next match
			if (match) begin
				case (output_mode_bits)
					`TMC_COM_NONE: nxt_oc = oc_ff;
					`TMC_COM_TOGGLE: nxt_oc = pwm ? oc_ff : ~oc_ff;
					`TMC_COM_CLEAR: nxt_oc = (wgm == tmc_pkg::TMC_PHASE) ? down_ff : 1'b0;
					default: nxt_oc = (wgm == tmc_pkg::TMC_PHASE) ? ~down_ff : 1'b1;
				endcase
				// Compare at max in fast mode gives a constant level, not a pulse
				if (wgm == tmc_pkg::TMC_FAST && at_max) begin
					nxt_oc = oc_ff;
				end
			end
			if (wgm == tmc_pkg::TMC_FAST && at_max && output_mode_bits[1]) begin
				// Level at bottom is the opposite of the match level
				nxt_oc = ~output_mode_bits[0];
			end
		end
		if (force_compare_strobe && !pwm) begin
			case (output_mode_bits)
				`TMC_COM_NONE: nxt_oc = oc_ff;
				`TMC_COM_TOGGLE: nxt_oc = ~oc_ff;
				`TMC_COM_CLEAR: nxt_oc = 1'b0;
				default: nxt_oc = 1'b1;
			endcase
		end
		if (compare_wr) begin
			if (pwm) begin
				nxt_buf = compare_wdata;
			end else begin
				nxt_cmp = compare_wdata;
				nxt_buf = compare_wdata;
			end
		end
		if (counter_wr) begin
			nxt_cnt = counter_wdata;
			nxt_block = 1'b1;
			nxt_match = 1'b0;
		end
		nxt_cmpv = pwm ? buf_ff : cmp_ff;
		if (compare_wr) begin
			nxt_cmpv = compare_wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Flags; a set in the same cycle as a clear wins
	always_comb begin
		nxt_ocf = ocf_set | (ocf_ff & ~(compare_flag_clr | compare_irq_ack));
		nxt_tov = tov_set | (tov_ff & ~(overflow_flag_clr | overflow_irq_ack));
		nxt_cirq = nxt_ocf & compare_irq_enable;
		nxt_oirq = nxt_tov & overflow_irq_enable;
		// Port override by waveform whenever output mode is nonzero
		nxt_pin = (output_mode_bits != `TMC_COM_NONE) ? nxt_oc : port_data;
		nxt_oe = output_pin_direction;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= `TMC_CNT_RST;
			down_ff <= 1'b0;
			cmp_ff <= `TMC_CMP_RST;
			buf_ff <= `TMC_CMP_RST;
			cmpv_ff <= `TMC_CMP_RST;
			block_ff <= 1'b0;
			match_ff <= 1'b0;
			ocf_ff <= 1'b0;
			tov_ff <= 1'b0;
			oc_ff <= 1'b0;
			cirq_ff <= 1'b0;
			oirq_ff <= 1'b0;
			pin_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			down_ff <= nxt_down;
			cmp_ff <= nxt_cmp;
			buf_ff <= nxt_buf;
			cmpv_ff <= nxt_cmpv;
			block_ff <= nxt_block;
			match_ff <= nxt_match;
			ocf_ff <= nxt_ocf;
			tov_ff <= nxt_tov;
			oc_ff <= nxt_oc;
			cirq_ff <= nxt_cirq;
			oirq_ff <= nxt_oirq;
			pin_ff <= nxt_pin;
			oe_ff <= nxt_oe;
		end
	end
	assign counter_value = cnt_ff;
	assign compare_value = cmpv_ff;
	assign compare_flag = ocf_ff;
	assign overflow_flag = tov_ff;
	assign compare_irq = cirq_ff;
	assign overflow_irq = oirq_ff;
	assign compare_output_state = oc_ff;
	// Oscillator drive is the external crystal's job; held low here
	assign osc_pin_out = 1'b0;
	assign pin_out = pin_ff;
	assign pin_oe = oe_ff;
endmodule : tmc_timer
`default_nettype wire

/* File: verif/tmc_timer_monitor.sv */
// Purpose: port assertions for tmc_timer
// Assumes: one clock, reset async active low
// Notes: force checks need the timer stopped for three cycles
`default_nettype none
module tmc_timer_monitor (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [2:0] clock_select_field,
	input wire logic [1:0] waveform_mode_bits,
	input wire logic [1:0] output_mode_bits,
	input wire logic compare_irq_enable,
	input wire logic counter_wr,
	input wire logic [7:0] counter_wdata,
	input wire logic compare_wr,
	input wire logic [7:0] compare_wdata,
	input wire logic force_compare_strobe,
	input wire logic port_data,
	input wire logic output_pin_direction,
	input wire logic [7:0] counter_value,
	input wire logic [7:0] compare_value,
	input wire logic compare_flag,
	input wire logic overflow_flag,
	input wire logic compare_irq,
	input wire logic compare_output_state,
	input wire logic pin_out,
	input wire logic pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////
	AST_CNT_WR: assert property (counter_wr |=> counter_value == $past(counter_wdata))
		else $error("counter write lost");
	AST_STOP: assert property ((clock_select_field == 3'h0 && !counter_wr)[*3] |=> $stable(counter_value))
		else $error("counter moved while stopped");
	AST_IRQ_CMP: assert property ($past(nrst) |-> compare_irq == (compare_flag && $past(compare_irq_enable)))
		else $error("compare irq wrong");
	AST_OVF_ZERO: assert property ($rose(overflow_flag) && waveform_mode_bits == 2'h0 |-> counter_value == 8'h00)
		else $error("overflow not at zero");
	AST_CMP_WR: assert property (compare_wr |=> compare_value == $past(compare_wdata))
		else $error("compare write lost");
	AST_PIN_PORT: assert property ((output_mode_bits == 2'h0 && $stable(port_data))[*2] |=> pin_out == $past(port_data))
		else $error("port value not on pin");
	// Pin and output state load from the same next value while output mode is nonzero, so they agree the cycle after
	AST_PIN_CMP: assert property (output_mode_bits != 2'h0 |=> pin_out == compare_output_state)
		else $error("output state not on pin");
	AST_OE: assert property ($past(nrst) |-> pin_oe == $past(output_pin_direction))
		else $error("pin enable wrong");
	AST_FORCE_FLAG: assert property ((clock_select_field == 3'h0)[*3] ##0 (force_compare_strobe && !compare_flag) |=> !compare_flag)
		else $error("force set the flag");
	AST_FORCE_TGL: assert property ((clock_select_field == 3'h0)[*3] ##0 (force_compare_strobe && waveform_mode_bits == 2'h0 && output_mode_bits == 2'h1) |=> compare_output_state != $past(compare_output_state))
		else $error("force did not toggle");
	////////
	COV_OVF: cover property ($rose(overflow_flag));
	COV_CMP: cover property ($rose(compare_flag));
	COV_FORCE: cover property (force_compare_strobe);
endmodule : tmc_timer_monitor
bind tmc_timer tmc_timer_monitor tmc_timer_monitor_i (
	.clk_sys(clk_sys), .nrst(nrst), .clock_select_field(clock_select_field),
	.waveform_mode_bits(waveform_mode_bits), .output_mode_bits(output_mode_bits),
	.compare_irq_enable(compare_irq_enable), .counter_wr(counter_wr),
	.counter_wdata(counter_wdata), .compare_wr(compare_wr), .compare_wdata(compare_wdata),
	.force_compare_strobe(force_compare_strobe), .port_data(port_data),
	.output_pin_direction(output_pin_direction), .counter_value(counter_value),
	.compare_value(compare_value), .compare_flag(compare_flag),
	.overflow_flag(overflow_flag), .compare_irq(compare_irq),
	.compare_output_state(compare_output_state), .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: self-checking bench for tmc_timer
// Assumes: inputs change 1 ns after the rising edge
// Notes: overflow_irq_ack stays low
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, nrst, osc_pin_in, async_clock_select, compare_irq_enable;
	logic [2:0] clock_select_field;
	logic [1:0] waveform_mode_bits, output_mode_bits;
	logic [7:0] counter_wdata, compare_wdata, counter_value, compare_value;
	logic overflow_irq_enable, counter_wr, compare_wr, force_compare_strobe, compare_flag_clr;
	logic overflow_flag_clr, compare_irq_ack, overflow_irq_ack, port_data, output_pin_direction;
	logic compare_flag, overflow_flag, compare_irq, overflow_irq, compare_output_state;
	logic osc_pin_out, pin_out, pin_oe;
	int fails, comparisons, cyc;
	tmc_timer tmc_timer_i (.clk_sys, .nrst, .osc_pin_in, .async_clock_select,
		.clock_select_field, .waveform_mode_bits, .output_mode_bits, .compare_irq_enable,
		.overflow_irq_enable, .counter_wr, .counter_wdata, .compare_wr, .compare_wdata,
		.force_compare_strobe, .compare_flag_clr, .overflow_flag_clr, .compare_irq_ack,
		.overflow_irq_ack, .port_data, .output_pin_direction, .counter_value, .compare_value,
		.compare_flag, .overflow_flag, .compare_irq, .overflow_irq, .compare_output_state,
		.osc_pin_out, .pin_out, .pin_oe);
	////////
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic load_cnt(input logic [7:0] v);
		counter_wr = 1'b1;
		counter_wdata = v;
		step(1);
		counter_wr = 1'b0;
	endtask : load_cnt
	////////
	task automatic t_overflow;
		overflow_irq_enable = 1'b1;
		clock_select_field = 3'h1;
		load_cnt(8'hFE);
		chk(counter_value, 8'hFE);
		for (int i = 0; i < 8 && !overflow_flag; i++) step(1);
		chk(counter_value, 8'h00);
		chk(8'(overflow_irq), 8'h01);
		overflow_flag_clr = 1'b1;
		step(1);
		overflow_flag_clr = 1'b0;
		chk(8'(overflow_flag), 8'h00);
	endtask : t_overflow
	task automatic t_stop_osc;
		clock_select_field = 3'h0;
		step(3);
		load_cnt(8'h40);
		step(20);
		chk(counter_value, 8'h40);
		async_clock_select = 1'b1;
		clock_select_field = 3'h1;
		repeat (5) begin
			osc_pin_in = 1'b1;
			step(4);
			osc_pin_in = 1'b0;
			step(4);
		end
		chk(counter_value, 8'h45);
		clock_select_field = 3'h0;
		async_clock_select = 1'b0;
	endtask : t_stop_osc
	// Counts up from 0x2D past the 0x30 match until the flag sets at 0x32, then stops the timer
	task automatic hit;
		load_cnt(8'h2D);
		clock_select_field = 3'h1;
		for (int i = 0; i < 12 && !compare_flag; i++) step(1);
		chk(counter_value, 8'h32);
		chk(8'(compare_irq), 8'h01);
		clock_select_field = 3'h0;
	endtask : hit
	task automatic t_compare;
		// The wrap to 00 in the overflow test matched the reset compare value
		compare_flag_clr = 1'b1;
		step(1);
		compare_flag_clr = 1'b0;
		step(2);
		compare_wr = 1'b1;
		compare_wdata = 8'h30;
		compare_irq_enable = 1'b1;
		load_cnt(8'h30);
		compare_wr = 1'b0;
		chk(compare_value, 8'h30);
		clock_select_field = 3'h1;
		step(4);
		chk(8'(compare_flag), 8'h00);
		clock_select_field = 3'h0;
		step(3);
		hit();
		compare_irq_ack = 1'b1;
		step(1);
		compare_irq_ack = 1'b0;
		chk(8'(compare_flag), 8'h00);
		hit();
		compare_flag_clr = 1'b1;
		step(1);
		compare_flag_clr = 1'b0;
		chk(8'(compare_flag), 8'h00);
	endtask : t_compare
	task automatic t_force_pin;
		logic [1:0] om [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
		logic [7:0] ex [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
		step(3);
		for (int i = 0; i < 4; i++) begin
			output_mode_bits = om[i];
			force_compare_strobe = 1'b1;
			step(1);
			force_compare_strobe = 1'b0;
			chk(8'(compare_output_state), ex[i]);
		end
		chk(8'(compare_flag), 8'h00);
		waveform_mode_bits = 2'h3;
		output_mode_bits = 2'h2;
		force_compare_strobe = 1'b1;
		compare_wr = 1'b1;
		compare_wdata = 8'h55;
		step(1);
		force_compare_strobe = 1'b0;
		compare_wr = 1'b0;
		chk(8'(compare_output_state), 8'h01);
		chk(compare_value, 8'h55);
		output_pin_direction = 1'b1;
		step(2);
		chk(8'(pin_out), 8'h01);
		chk(8'(pin_oe), 8'h01);
		output_mode_bits = 2'h0;
		step(2);
		chk(8'(pin_out), 8'h00);
	endtask : t_force_pin
	// Clear on match, phase correct with a buffered compare, then the /8 prescaler
	task automatic t_modes;
		waveform_mode_bits = 2'h2;
		compare_wr = 1'b1;
		compare_wdata = 8'h05;
		load_cnt(8'h03);
		compare_wr = 1'b0;
		clock_select_field = 3'h1;
		step(4);
		chk(counter_value, 8'h00);
		chk(8'(overflow_flag), 8'h00);
		clock_select_field = 3'h0;
		step(2);
		chk(8'(compare_flag), 8'h01);
		compare_flag_clr = 1'b1;
		waveform_mode_bits = 2'h1;
		output_mode_bits = 2'h3;
		compare_wr = 1'b1;
		compare_wdata = 8'hFD;
		load_cnt(8'hFC);
		compare_flag_clr = 1'b0;
		compare_wr = 1'b0;
		clock_select_field = 3'h1;
		step(5);
		chk(counter_value, 8'hFE);
		// An unbuffered write would already have matched on the way up
		chk(8'(compare_flag), 8'h00);
		step(2);
		chk(8'(compare_output_state), 8'h00);
		clock_select_field = 3'h0;
		step(2);
		chk(8'(compare_flag), 8'h01);
		waveform_mode_bits = 2'h0;
		load_cnt(8'h10);
		clock_select_field = 3'h2;
		step(17);
		chk(counter_value, 8'h12);
		clock_select_field = 3'h0;
	endtask : t_modes
	////////
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Cuts a hang short well past the roughly 150 cycles the tests need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			finish_test();
		end
	end
	initial begin
		{nrst, osc_pin_in, async_clock_select, clock_select_field, waveform_mode_bits} = '0;
		{output_mode_bits, compare_irq_enable, overflow_irq_enable, counter_wr} = '0;
		{counter_wdata, compare_wr, compare_wdata, force_compare_strobe, compare_flag_clr} = '0;
		{overflow_flag_clr, compare_irq_ack, overflow_irq_ack, port_data} = '0;
		output_pin_direction = 1'b0;
		step(10);
		nrst = 1'b1;
		step(1);
		chk(counter_value, 8'h00);
		chk(8'(osc_pin_out), 8'h00);
		t_overflow();
		t_stop_osc();
		t_compare();
		t_force_pin();
		t_modes();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
